/* File: hw/fan_regs_pkg.sv */
// constants for the per-fan tachometer target register slice
package fan_regs_pkg;
    localparam int          FAN_COUNT          = 5;
    localparam int          COUNT_W            = 13;
    localparam int          LOW_W              = 5;
    localparam int          LOW_POS            = 3;
    localparam int          HIGH_W             = 8;
    // fan one addresses, later fans follow at the stride
    localparam logic [7:0]  ADDR_FAIL_BAND_LOW = 8'h3a;
    localparam logic [7:0]  ADDR_GOAL_LOW      = 8'h3c;
    localparam logic [7:0]  ADDR_GOAL_HIGH     = 8'h3d;
    localparam logic [7:0]  ADDR_MEAS_HIGH     = 8'h3e;
    localparam logic [7:0]  ADDR_MEAS_LOW      = 8'h3f;
    localparam logic [7:0]  FAN_STRIDE         = 8'h10;
    localparam logic [7:0]  RESET_BYTE         = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ      = 8'h00;
    localparam logic [7:0]  GOAL_OFF_HIGH      = 8'hff;
    // fail period choices, in update periods
    localparam logic [1:0]  FAIL_SEL_OFF       = 2'h0;
    localparam logic [6:0]  FAIL_PERIODS_16    = 7'h10;
    localparam logic [6:0]  FAIL_PERIODS_32    = 7'h20;
    localparam logic [6:0]  FAIL_PERIODS_64    = 7'h40;
endpackage

/* File: hw/fan_goal_slice.sv */
// one fan's band, target and reading registers
`timescale 1ns/1ns
`default_nettype none
module fan_goal_slice (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // host writes
    input  wire logic                                 wr_band_low,
    input  wire logic                                 wr_goal_low,
    input  wire logic                                 wr_goal_high,
    input  wire logic                                 wr_meas_high,
    input  wire logic                                 wr_meas_low,
    input  wire logic [7:0]                           wdata,
    // device side updates
    input  wire logic                                 alg_load,
    input  wire logic [fan_regs_pkg::COUNT_W-1:0]     alg_goal,
    input  wire logic                                 meas_load,
    input  wire logic [fan_regs_pkg::COUNT_W-1:0]     meas_count,
    // register contents
    output logic      [fan_regs_pkg::LOW_W-1:0]       band_low,
    output logic      [fan_regs_pkg::LOW_W-1:0]       stage_low,
    output logic      [fan_regs_pkg::COUNT_W-1:0]     goal,
    output logic      [fan_regs_pkg::COUNT_W-1:0]     meas
);
    logic [fan_regs_pkg::LOW_W-1:0]   band_low_r,  band_low_nxt;
    logic [fan_regs_pkg::LOW_W-1:0]   stage_low_r, stage_low_nxt;
    logic [fan_regs_pkg::COUNT_W-1:0] goal_r,      goal_nxt;
    logic [fan_regs_pkg::COUNT_W-1:0] meas_r,      meas_nxt;

    always_comb begin
        band_low_nxt  = band_low_r;
        stage_low_nxt = stage_low_r;
        goal_nxt      = goal_r;
        meas_nxt      = meas_r;
        if (wr_band_low) begin
            band_low_nxt = wdata[7:fan_regs_pkg::LOW_POS]; // R1
        end
        // low byte only stages; the active goal is untouched
        if (wr_goal_low) begin
            stage_low_nxt = wdata[7:fan_regs_pkg::LOW_POS]; // R6 R9
        end
        if (alg_load) begin
            goal_nxt      = alg_goal; // R2 R3
            stage_low_nxt = alg_goal[fan_regs_pkg::LOW_W-1:0];
        end
        // host high write sets bits 12..5 over an algorithm update in the same cycle; bits 4..0 take the algorithm's value
        if (wr_goal_high) begin
            goal_nxt = {wdata, stage_low_nxt}; // R7 R8
        end
        if (wr_meas_high) begin
            meas_nxt[fan_regs_pkg::COUNT_W-1:fan_regs_pkg::LOW_W] = wdata;
        end
        if (wr_meas_low) begin
            meas_nxt[fan_regs_pkg::LOW_W-1:0] = wdata[7:fan_regs_pkg::LOW_POS];
        end
        if (meas_load) begin
            meas_nxt = meas_count; // R10
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            band_low_r  <= '0;
            stage_low_r <= '0;
            goal_r      <= '0;
            meas_r      <= '0;
        end else begin
            band_low_r  <= band_low_nxt;
            stage_low_r <= stage_low_nxt;
            goal_r      <= goal_nxt;
            meas_r      <= meas_nxt;
        end
    end

    assign band_low  = band_low_r;
    assign stage_low = stage_low_r;
    assign goal      = goal_r;
    assign meas      = meas_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LOW_ONLY_HOLDS: assert property ( // R6
        (wr_goal_low && !wr_goal_high && !alg_load) |=> (goal_r == $past(goal_r)))
        else $error("low byte write changed the active goal");
    AST_HIGH_APPLIES: assert property ( // R7
        (wr_goal_high && !alg_load) |=> (goal_r == {$past(wdata), stage_low_r}))
        else $error("high byte write did not apply both bytes");
    AST_MEAS_TAKES: assert property ( // R10
        meas_load |=> (meas_r == $past(meas_count)))
        else $error("measurement not presented");
    COV_STAGED_APPLY: cover property (wr_goal_low ##[1:8] wr_goal_high);
endmodule
`default_nettype wire

/* File: hw/fan_tach_target_regs.sv */
// register bank for fan targets, fail band and tach readings, with aging check
//
// How it works
// R1 - band low bits sit in bits 7..3
// R2 - each fan keeps a target count
// R3 - target reads return the active target
// R4 - target FFh forces the drive off
// R5 - leaving FFh starts a spin-up first
// R6 - low byte write alone changes nothing
// R7 - high byte write applies both bytes
// R8 - target high holds count bits 12..5
// R9 - target low holds bits 4..0, rest zero
// R10 - each fan presents its latest measurement; host writes to the reading bytes replace it until the next measurement lands
// R11 - reading high holds count bits 12..5
// R12 - five fans at 0x10 address stride
// R13 - full drive below goal flags aging fan
// R14 - reading low holds bits 4..0, rest zero
// R15 - host writes low byte before high
`timescale 1ns/1ns
`default_nettype none
module fan_tach_target_regs (
    // clock and reset
    input  wire logic                                            CORE_CLK,
    input  wire logic                                            RST,
    // register port behind the management bus
    input  wire logic [7:0]                                      REG_ADDR,
    input  wire logic                                            REG_WR,
    input  wire logic [7:0]                                      REG_WDATA,
    input  wire logic                                            REG_RD,
    output logic      [7:0]                                      REG_RDATA,
    output logic                                                 REG_RVALID,
    // speed loop side
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0]              ALG_ENABLE,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0]              ALG_GOAL_LOAD,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0][12:0]        ALG_GOAL,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0]              UPDATE_TICK,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0]              DRIVE_FULL,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0][1:0]         FAIL_PERIOD_SELECT,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0][7:0]         FAIL_BAND_HIGH,
    // tach measurement side
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0]              MEAS_LOAD,
    input  wire logic [fan_regs_pkg::FAN_COUNT-1:0][12:0]        MEAS_COUNT,
    // per fan results
    output logic      [fan_regs_pkg::FAN_COUNT-1:0][12:0]        SPEED_GOAL_COUNT,
    output logic      [fan_regs_pkg::FAN_COUNT-1:0]              DRIVE_FORCE_OFF,
    output logic      [fan_regs_pkg::FAN_COUNT-1:0]              SPINUP_START,
    output logic      [fan_regs_pkg::FAN_COUNT-1:0]              DRIVE_FAIL_EVENT
);
    localparam int N = fan_regs_pkg::FAN_COUNT;

    typedef enum {SEL_NONE, SEL_BAND_LOW, SEL_GOAL_LOW, SEL_GOAL_HIGH, SEL_MEAS_HIGH, SEL_MEAS_LOW} reg_sel_t;

    // fan index from the address page; out of range pages give N
    function automatic logic [2:0] fan_of(input logic [7:0] addr);
        logic [3:0] page;
        page = addr[7:4] - fan_regs_pkg::ADDR_GOAL_LOW[7:4];
        if (addr[7:4] < fan_regs_pkg::ADDR_GOAL_LOW[7:4] || page >= 4'(N)) begin
            return 3'(N);
        end
        return page[2:0];
    endfunction

    function automatic reg_sel_t sel_of(input logic [7:0] addr);
        reg_sel_t s;
        s = SEL_NONE;
        if (fan_of(addr) != 3'(N)) begin
            case (addr[3:0])
                fan_regs_pkg::ADDR_FAIL_BAND_LOW[3:0]: s = SEL_BAND_LOW;
                fan_regs_pkg::ADDR_GOAL_LOW[3:0]:      s = SEL_GOAL_LOW;
                fan_regs_pkg::ADDR_GOAL_HIGH[3:0]:     s = SEL_GOAL_HIGH;
                fan_regs_pkg::ADDR_MEAS_HIGH[3:0]:     s = SEL_MEAS_HIGH;
                fan_regs_pkg::ADDR_MEAS_LOW[3:0]:      s = SEL_MEAS_LOW;
                default:                               s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    function automatic logic [6:0] fail_limit(input logic [1:0] sel);
        case (sel)
            2'h1:    return fan_regs_pkg::FAIL_PERIODS_16;
            2'h2:    return fan_regs_pkg::FAIL_PERIODS_32;
            default: return fan_regs_pkg::FAIL_PERIODS_64;
        endcase
    endfunction

    logic [2:0] wr_fan;
    reg_sel_t   wr_sel;
    logic [2:0] rd_fan;
    reg_sel_t   rd_sel;

    assign wr_fan = fan_of(REG_ADDR); // R12
    assign wr_sel = sel_of(REG_ADDR);
    assign rd_fan = wr_fan;
    assign rd_sel = wr_sel;

    logic [4:0]  band_low  [N];
    logic [12:0] goal      [N];
    logic [12:0] meas      [N];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_fan
            logic hit;
            assign hit = REG_WR && (wr_fan == 3'(g));
            fan_goal_slice u_slice (
                .clk          (CORE_CLK),
                .rst          (RST),
                .wr_band_low  (hit && wr_sel == SEL_BAND_LOW),
                .wr_goal_low  (hit && wr_sel == SEL_GOAL_LOW),
                .wr_goal_high (hit && wr_sel == SEL_GOAL_HIGH),
                .wr_meas_high (hit && wr_sel == SEL_MEAS_HIGH),
                .wr_meas_low  (hit && wr_sel == SEL_MEAS_LOW),
                .wdata        (REG_WDATA),
                .alg_load     (ALG_GOAL_LOAD[g]),
                .alg_goal     (ALG_GOAL[g]),
                .meas_load    (MEAS_LOAD[g]),
                .meas_count   (MEAS_COUNT[g]),
                .band_low     (band_low[g]),
                .stage_low    (),
                .goal         (goal[g]),
                .meas         (meas[g])
            );
            assign SPEED_GOAL_COUNT[g] = goal[g];
        end
    endgenerate

    // read path: one cycle latency, data from a flip-flop
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;

    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = REG_RD;
        if (REG_RD) begin
            rdata_nxt = fan_regs_pkg::UNMAPPED_READ;
            if (rd_fan != 3'(N)) begin
                case (rd_sel)
                    SEL_BAND_LOW:  rdata_nxt = {band_low[rd_fan], 3'h0};                 // R1
                    SEL_GOAL_LOW:  rdata_nxt = {goal[rd_fan][4:0], 3'h0};                // R3 R9
                    SEL_GOAL_HIGH: rdata_nxt = goal[rd_fan][12:5];                       // R3 R8
                    SEL_MEAS_HIGH: rdata_nxt = meas[rd_fan][12:5];                       // R11
                    SEL_MEAS_LOW:  rdata_nxt = {meas[rd_fan][4:0], 3'h0};                // R14
                    default:       rdata_nxt = fan_regs_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rdata_r  <= fan_regs_pkg::RESET_BYTE;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign REG_RDATA  = rdata_r;
    assign REG_RVALID = rvalid_r;

    // drive off, spin-up and aging detection per fan
    logic [N-1:0] off_r,  off_nxt;
    logic [N-1:0] spin_r, spin_nxt;
    logic [N-1:0] was_off_r, was_off_nxt;
    logic [N-1:0] fail_r, fail_nxt;
    logic [6:0]   fail_cnt_r [N];
    logic [6:0]   fail_cnt_nxt [N];

    always_comb begin
        for (int i = 0; i < N; i++) begin
            logic        at_off;
            logic [13:0] slow_edge;
            logic        slow;
            at_off          = (goal[i][12:5] == fan_regs_pkg::GOAL_OFF_HIGH);
            // tach counts are periods, so a larger count is a slower fan
            slow_edge       = {1'b0, goal[i]} + {1'b0, FAIL_BAND_HIGH[i], band_low[i]};
            slow            = {1'b0, meas[i]} > slow_edge;
            off_nxt[i]      = ALG_ENABLE[i] && at_off; // R4
            was_off_nxt[i]  = at_off;
            spin_nxt[i]     = ALG_ENABLE[i] && was_off_r[i] && !at_off; // R5
            fail_nxt[i]     = 1'b0;
            fail_cnt_nxt[i] = fail_cnt_r[i];
            // the band only matters at full drive under closed-loop control
            if (!ALG_ENABLE[i] || !DRIVE_FULL[i] || FAIL_PERIOD_SELECT[i] == fan_regs_pkg::FAIL_SEL_OFF || !slow) begin
                fail_cnt_nxt[i] = '0;
            end else if (UPDATE_TICK[i]) begin
                if (fail_cnt_r[i] == fail_limit(FAIL_PERIOD_SELECT[i])) begin
                    // saturate so the event fires once per slow stretch
                    fail_cnt_nxt[i] = fail_cnt_r[i] + 7'h1;
                    fail_nxt[i]     = 1'b1; // R13
                end else if (fail_cnt_r[i] < fail_limit(FAIL_PERIOD_SELECT[i])) begin
                    fail_cnt_nxt[i] = fail_cnt_r[i] + 7'h1;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            off_r     <= '0;
            spin_r    <= '0;
            was_off_r <= '0;
            fail_r    <= '0;
            for (int i = 0; i < N; i++) begin
                fail_cnt_r[i] <= '0;
            end
        end else begin
            off_r     <= off_nxt;
            spin_r    <= spin_nxt;
            was_off_r <= was_off_nxt;
            fail_r    <= fail_nxt;
            for (int i = 0; i < N; i++) begin
                fail_cnt_r[i] <= fail_cnt_nxt[i];
            end
        end
    end

    assign DRIVE_FORCE_OFF  = off_r;
    assign SPINUP_START     = spin_r;
    assign DRIVE_FAIL_EVENT = fail_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    AST_FORCE_OFF: assert property ( // R4
        (ALG_ENABLE[0] && goal[0][12:5] == 8'hff) |=> DRIVE_FORCE_OFF[0])
        else $error("target FFh did not force drive off");
    AST_OFF_ONLY_AT_FF: assert property ( // R4
        DRIVE_FORCE_OFF[0] |-> ($past(goal[0][12:5]) == 8'hff && $past(ALG_ENABLE[0])))
        else $error("drive forced off without FFh target");
    AST_SPINUP_ON_LEAVE: assert property ( // R5
        (ALG_ENABLE[0] && goal[0][12:5] == 8'hff ##1 ALG_ENABLE[0] && goal[0][12:5] != 8'hff)
        |=> SPINUP_START[0])
        else $error("leaving FFh did not start spin-up");
    AST_GOAL_HIGH_READ: assert property ( // R3
        (REG_RD && REG_ADDR == 8'h3d) |=> (REG_RVALID && REG_RDATA == $past(goal[0][12:5])))
        else $error("target high read wrong");
    AST_FAN5_STRIDE: assert property ( // R12
        (REG_RD && REG_ADDR == 8'h7c) |=> (REG_RDATA == {$past(goal[4][4:0]), 3'h0}))
        else $error("fan five target low read wrong");
    AST_LOW_PAD_ZERO: assert property ( // R14
        (REG_RD && REG_ADDR[3:0] inside {4'ha, 4'hc, 4'hf}) |=> (REG_RDATA[2:0] == 3'h0))
        else $error("unimplemented low bits not zero");
    AST_MEAS_HIGH_READ: assert property ( // R11
        (REG_RD && REG_ADDR == 8'h4e) |=> (REG_RDATA == $past(meas[1][12:5])))
        else $error("reading high byte wrong");
    AST_FAIL_NEEDS_FULL: assert property ( // R13
        DRIVE_FAIL_EVENT[0] |-> ($past(DRIVE_FULL[0]) && $past(UPDATE_TICK[0]) && $past(fail_cnt_r[0]) >= 7'h10))
        else $error("drive fail raised without a full slow stretch");
    AST_FAIL_SINGLE: assert property ( // R13
        DRIVE_FAIL_EVENT[0] |=> !DRIVE_FAIL_EVENT[0])
        else $error("drive fail event longer than one cycle");

    // read port timing and more per fan checks
    AST_RVALID_FOLLOWS: assert property ( // R3
        REG_RVALID == $past(REG_RD))
        else $error("read answer not one cycle after read");
    AST_RDATA_HOLDS: assert property ( // R3
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    AST_HOLE_READ: assert property ( // R12
        (REG_RD && sel_of(REG_ADDR) == SEL_NONE) |=> (REG_RDATA == fan_regs_pkg::UNMAPPED_READ))
        else $error("unmapped read not fixed value");
    AST_BAND_LOW_READ: assert property ( // R1
        (REG_RD && REG_ADDR == fan_regs_pkg::ADDR_FAIL_BAND_LOW) |=> (REG_RDATA == {$past(band_low[0]), 3'h0}))
        else $error("band low read wrong");
    AST_GOAL_LOW_READ: assert property ( // R9
        (REG_RD && REG_ADDR == fan_regs_pkg::ADDR_GOAL_LOW) |=> (REG_RDATA == {$past(goal[0][4:0]), 3'h0}))
        else $error("target low read wrong");
    AST_MEAS_LOW_READ: assert property ( // R14
        (REG_RD && REG_ADDR == fan_regs_pkg::ADDR_MEAS_LOW + fan_regs_pkg::FAN_STRIDE)
        |=> (REG_RDATA == {$past(meas[1][4:0]), 3'h0}))
        else $error("reading low byte wrong");
    AST_SPIN_ONLY_ON_LEAVE: assert property ( // R5
        SPINUP_START[0] |-> ($past(ALG_ENABLE[0]) && $past(goal[0][12:5]) != 8'hff
            && $past(goal[0][12:5], 2) == 8'hff))
        else $error("spin-up without leaving FFh");
    AST_SPIN_SINGLE: assert property ( // R5
        SPINUP_START[0] |=> !SPINUP_START[0])
        else $error("spin-up pulse too long");
    AST_FAIL_NEEDS_SLOW: assert property ( // R13
        DRIVE_FAIL_EVENT[0] |-> ($past(ALG_ENABLE[0]) && $past(meas[0]) > $past(goal[0])))
        else $error("drive fail raised while not slow");
    AST_FAIL_COUNT_DROPS: assert property ( // R13
        !DRIVE_FULL[0] |=> (fail_cnt_r[0] == 7'h0))
        else $error("slow stretch kept below full drive");
    AST_GOAL_HIGH_WRITE: assert property ( // R8
        (REG_WR && REG_ADDR == fan_regs_pkg::ADDR_GOAL_HIGH) |=> (goal[0][12:5] == $past(REG_WDATA)))
        else $error("target high byte not applied");
    AST_LOW_WRITE_HOLDS: assert property ( // R6
        (REG_WR && REG_ADDR == fan_regs_pkg::ADDR_GOAL_LOW && !ALG_GOAL_LOAD[0]) |=> $stable(SPEED_GOAL_COUNT[0]))
        else $error("target low byte applied alone");
    AST_OTHER_FAN_APART: assert property ( // R12
        (REG_WR && REG_ADDR == fan_regs_pkg::ADDR_GOAL_HIGH + fan_regs_pkg::FAN_STRIDE && !ALG_GOAL_LOAD[0])
        |=> $stable(goal[0]))
        else $error("fan two write reached fan one");

    COV_SPINUP: cover property (SPINUP_START[0]);
    COV_FAIL: cover property (DRIVE_FAIL_EVENT[0]);
    COV_READ_FAN5: cover property (REG_RD && REG_ADDR == 8'h7d);
    COV_FORCE_OFF: cover property (DRIVE_FORCE_OFF[0]);
endmodule
`default_nettype wire

/* File: tb/fan_host.sv */
// management bus host model driving the register strobe port
`timescale 1ns/1ns
`default_nettype none
module fan_host (
    // clock
    input  wire logic       clk,
    // register strobes
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // one strobe cycle, launched and released on falling edges
    task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = ~w;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // idle lines show the inverse so a stale value cannot pass for a live one
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // low byte first so both halves of a new target land together
    task automatic goal_wr(input logic [7:0] a_low, input logic [7:0] lo, input logic [7:0] hi);
        strobe(a_low, lo, 1'b1);
        strobe(a_low + 8'h01, hi, 1'b1);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the fan target register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    localparam int NF = fan_regs_pkg::FAN_COUNT;
    logic                CORE_CLK;
    logic                RST;
    logic      [7:0]     REG_ADDR;
    logic                REG_WR;
    logic      [7:0]     REG_WDATA;
    logic                REG_RD;
    logic      [7:0]     REG_RDATA;
    logic                REG_RVALID;
    logic      [NF-1:0]  ALG_ENABLE;
    logic      [NF-1:0]  ALG_GOAL_LOAD;
    logic [NF-1:0][12:0] ALG_GOAL;
    logic      [NF-1:0]  UPDATE_TICK;
    logic      [NF-1:0]  DRIVE_FULL;
    logic [NF-1:0][1:0]  FAIL_PERIOD_SELECT;
    logic [NF-1:0][7:0]  FAIL_BAND_HIGH;
    logic      [NF-1:0]  MEAS_LOAD;
    logic [NF-1:0][12:0] MEAS_COUNT;
    logic [NF-1:0][12:0] SPEED_GOAL_COUNT;
    logic      [NF-1:0]  DRIVE_FORCE_OFF;
    logic      [NF-1:0]  SPINUP_START;
    logic      [NF-1:0]  DRIVE_FAIL_EVENT;
    int                  error_cnt = 0;
    int                  n_tests = 0;
    int                  spin_cnt = 0;
    int                  fail_cnt = 0;
    int                  cyc = 0;
    int                  seed;
    logic      [7:0]     exp_q[$];
    logic      [7:0]     e_rd;
    logic      [7:0]     base, lo, hi, bl;
    logic      [12:0]    g, m;
    logic      [7:0]     map [5] = '{fan_regs_pkg::ADDR_FAIL_BAND_LOW, fan_regs_pkg::ADDR_GOAL_LOW,
        fan_regs_pkg::ADDR_GOAL_HIGH, fan_regs_pkg::ADDR_MEAS_HIGH, fan_regs_pkg::ADDR_MEAS_LOW};

    fan_host i_fan_host (.clk(CORE_CLK), .reg_addr(REG_ADDR), .reg_wr(REG_WR), .reg_wdata(REG_WDATA),
        .reg_rd(REG_RD));

    fan_tach_target_regs i_fan_tach_target_regs (.CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .ALG_ENABLE(ALG_ENABLE), .ALG_GOAL_LOAD(ALG_GOAL_LOAD), .ALG_GOAL(ALG_GOAL),
        .UPDATE_TICK(UPDATE_TICK), .DRIVE_FULL(DRIVE_FULL), .FAIL_PERIOD_SELECT(FAIL_PERIOD_SELECT),
        .FAIL_BAND_HIGH(FAIL_BAND_HIGH), .MEAS_LOAD(MEAS_LOAD), .MEAS_COUNT(MEAS_COUNT),
        .SPEED_GOAL_COUNT(SPEED_GOAL_COUNT), .DRIVE_FORCE_OFF(DRIVE_FORCE_OFF), .SPINUP_START(SPINUP_START),
        .DRIVE_FAIL_EVENT(DRIVE_FAIL_EVENT));

    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end

    task automatic finish_test();
        if (exp_q.size() != 0) error_cnt++;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the note is taken now, the monitor matches it to the answer
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        i_fan_host.strobe(a, 8'h00, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_fan_host.strobe(a, d, 1'b1);
    endtask

    task automatic tick();
        @(negedge CORE_CLK);
        UPDATE_TICK[0] = 1'b1;
        @(negedge CORE_CLK);
        UPDATE_TICK[0] = 1'b0;
    endtask

    always @(negedge CORE_CLK) begin
        cyc++;
        spin_cnt += $countones(SPINUP_START);
        fail_cnt += $countones(DRIVE_FAIL_EVENT);
        if (REG_RVALID === 1'b1) begin
            e_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK("rdata", e_rd, REG_RDATA)
        end
        if (cyc == 6000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        seed = 68755;
        RST = 1'b1;
        {ALG_ENABLE, ALG_GOAL_LOAD, UPDATE_TICK, DRIVE_FULL, MEAS_LOAD} = '0;
        ALG_GOAL = '0;
        MEAS_COUNT = '0;
        FAIL_PERIOD_SELECT = '0;
        FAIL_BAND_HIGH = '0;
        repeat (2) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST = 1'b0;
        // every register of every fan starts cleared; a hole reads the fixed value
        for (int k = 0; k < NF; k++)
            for (int r = 0; r < 5; r++)
                rd_chk(map[r] + fan_regs_pkg::FAN_STRIDE * 8'(k), fan_regs_pkg::RESET_BYTE);
        rd_chk(8'h30, fan_regs_pkg::UNMAPPED_READ);
        for (int k = 0; k < NF; k++) begin
            base = fan_regs_pkg::FAN_STRIDE * 8'(k);
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            bl = 8'($random(seed));
            wr(base + fan_regs_pkg::ADDR_FAIL_BAND_LOW, bl);
            rd_chk(base + fan_regs_pkg::ADDR_FAIL_BAND_LOW, {bl[7:3], 3'h0});
            // a low byte alone leaves the active target untouched
            wr(base + fan_regs_pkg::ADDR_GOAL_LOW, lo);
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_LOW, 8'h00);
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_HIGH, 8'h00);
            wr(base + fan_regs_pkg::ADDR_GOAL_HIGH, hi);
            @(negedge CORE_CLK);
            `CHK("goal", {hi, lo[7:3]}, SPEED_GOAL_COUNT[k])
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_HIGH, hi);
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_LOW, {lo[7:3], 3'h0});
            // a second high write reuses the staged low byte
            wr(base + fan_regs_pkg::ADDR_GOAL_HIGH, ~hi);
            @(negedge CORE_CLK);
            `CHK("goal2", {~hi, lo[7:3]}, SPEED_GOAL_COUNT[k])
            g = 13'($random(seed));
            @(negedge CORE_CLK);
            ALG_GOAL[k] = g;
            ALG_GOAL_LOAD[k] = 1'b1;
            @(negedge CORE_CLK);
            ALG_GOAL_LOAD[k] = 1'b0;
            `CHK("alggoal", g, SPEED_GOAL_COUNT[k])
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_HIGH, g[12:5]);
            rd_chk(base + fan_regs_pkg::ADDR_GOAL_LOW, {g[4:0], 3'h0});
            // reading registers take host writes until the next measurement lands
            wr(base + fan_regs_pkg::ADDR_MEAS_HIGH, lo);
            wr(base + fan_regs_pkg::ADDR_MEAS_LOW, hi);
            rd_chk(base + fan_regs_pkg::ADDR_MEAS_HIGH, lo);
            rd_chk(base + fan_regs_pkg::ADDR_MEAS_LOW, {hi[7:3], 3'h0});
            m = 13'($random(seed));
            @(negedge CORE_CLK);
            MEAS_COUNT[k] = m;
            MEAS_LOAD[k] = 1'b1;
            @(negedge CORE_CLK);
            MEAS_LOAD[k] = 1'b0;
            rd_chk(base + fan_regs_pkg::ADDR_MEAS_HIGH, m[12:5]);
            rd_chk(base + fan_regs_pkg::ADDR_MEAS_LOW, {m[4:0], 3'h0});
        end
        // stop target with the loop on, then leave it
        ALG_ENABLE[0] = 1'b1;
        i_fan_host.goal_wr(fan_regs_pkg::ADDR_GOAL_LOW, 8'h00, fan_regs_pkg::GOAL_OFF_HIGH);
        repeat (3) @(negedge CORE_CLK);
        `CHK("force_off", 1'b1, DRIVE_FORCE_OFF[0])
        `CHK("spin_none", 0, spin_cnt)
        i_fan_host.goal_wr(fan_regs_pkg::ADDR_GOAL_LOW, 8'h08, 8'h01);
        repeat (3) @(negedge CORE_CLK);
        `CHK("force_on", 1'b0, DRIVE_FORCE_OFF[0])
        `CHK("spin_one", 1, spin_cnt)
        // full drive while far below the goal: 16 periods pass, the next one flags
        DRIVE_FULL[0] = 1'b1;
        FAIL_PERIOD_SELECT[0] = 2'h1;
        MEAS_COUNT[0] = 13'h1fff;
        MEAS_LOAD[0] = 1'b1;
        @(negedge CORE_CLK);
        MEAS_LOAD[0] = 1'b0;
        repeat (16) tick();
        repeat (2) @(negedge CORE_CLK);
        `CHK("fail_early", 0, fail_cnt)
        tick();
        repeat (2) @(negedge CORE_CLK);
        `CHK("fail_hit", 1, fail_cnt)
        repeat (4) tick();
        repeat (2) @(negedge CORE_CLK);
        `CHK("fail_once", 1, fail_cnt)
        // leaving full drive restarts the stretch; the 32 period choice flags one tick later
        DRIVE_FULL[0] = 1'b0;
        FAIL_PERIOD_SELECT[0] = 2'h2;
        @(negedge CORE_CLK);
        DRIVE_FULL[0] = 1'b1;
        repeat (int'(fan_regs_pkg::FAIL_PERIODS_32)) tick();
        repeat (2) @(negedge CORE_CLK);
        `CHK("fail32_early", 1, fail_cnt)
        tick();
        repeat (2) @(negedge CORE_CLK);
        `CHK("fail32_hit", 2, fail_cnt)
        repeat (4) @(negedge CORE_CLK);
        finish_test();
    end
endmodule
`default_nettype wire
